// file: cmc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmc_core_model (
   // Clock and reset.
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Offer from the mailbox block and pacing from the bench.
   input  wire logic       tx_valid,
   input  wire logic       go,
   input  wire logic [4:0] gap,
   // Progress of the offered frame.
   output logic            tx_start,
   output logic            tx_done
);
   logic [1:0] phase;
   logic [4:0] cnt;

   // The cool-down phase keeps a stale offer from being started again before the block has taken the done pulse.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         phase    <= 2'h0;
         cnt      <= 5'h0;
         tx_start <= 1'b0;
         tx_done  <= 1'b0;
      end
      else
      begin
         tx_start <= 1'b0;
         tx_done  <= 1'b0;
         cnt      <= cnt + 5'h1;
         if (phase == 2'h2)
         begin
            if (cnt == 5'h3)
            begin
               phase <= 2'h0;
               cnt   <= 5'h0;
            end
         end
         else if (!(go && tx_valid))
            cnt <= (phase == 2'h0) ? 5'h0 : cnt;
         else if (cnt >= gap)
         begin
            cnt      <= 5'h0;
            tx_start <= (phase == 2'h0);
            tx_done  <= (phase == 2'h1);
            phase    <= phase + 2'h1;
         end
      end
   end
endmodule : cmc_core_model
`default_nettype wire

// file: cmc_mailbox.sv
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cmc_mailbox
   import cmc_pkg::*;
#(
   parameter int MB_NUM = 8
)(
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Protocol core, transmit side.
   output logic             tx_valid,
   output logic [2:0]       tx_mb,
   output logic             tx_rtr,
   input  wire logic        tx_start,
   input  wire logic        tx_done,
   // Protocol core, receive side.
   input  wire logic        rx_valid,
   input  wire logic [28:0] rx_id,
   input  wire logic        rx_rtr,
   output logic             rx_hit,
   output logic [2:0]       rx_mb,
   output logic             rx_store,
   output logic             rx_drop,
   // Abort interrupt request.
   output logic             abort_irq
);
   import cmc_pkg::*;

   if (MB_NUM < 1 || MB_NUM > CMC_MB_MAX)
   begin : g_bad
      $error("MB_NUM must be 1 to 8");
   end

   cmc_state_s q;
   cmc_state_s n;
   logic [CMC_MB_MAX-1:0] elig_q;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic is_txt(input logic [2:0] t);
      is_txt = (t == CMC_OT_TX) || (t == CMC_OT_CONS) || (t == CMC_OT_PROD);
   endfunction : is_txt

   function automatic logic [28:0] fam_pack(input logic [29:0] idv, input logic [29:0] m);
      logic [28:0] r;
      logic [4:0]  k;
      r = '0;
      k = '0;
      for (int b = 0; b < 29; b++)
      begin
         if (m[b])
         begin
            r[k] = idv[b];
            k = k + 5'h01;
         end
      end
      fam_pack = r;
   endfunction : fam_pack

   function automatic logic id_match(input logic [29:0] idv, input logic [29:0] m,
                                     input logic [28:0] f);
      logic [28:0] d;
      d = (idv[28:0] ^ f) & m[28:0];
      id_match = (d[28:CMC_STD_LSB] == '0) &&
                 (!m[CMC_IDE_BIT] || d[CMC_STD_LSB-1:0] == '0);
   endfunction : id_match

   // Transmit candidates; a frame already in flight stays a candidate until done, but a higher-priority candidate can take the offer.
   function automatic logic [CMC_MB_MAX-1:0] elig(input cmc_state_s s);
      logic [CMC_MB_MAX-1:0] e;
      e = '0;
      for (int i = 0; i < MB_NUM; i++)
      begin
         e[i] = s.pend[i] && ((s.object_type[i] == CMC_OT_TX) ||
                (s.object_type[i] == CMC_OT_CONS && !s.rsent[i]) ||
                (s.object_type[i] == CMC_OT_PROD && s.rgot[i])) &&
                (!s.ttm || s.timer >= s.tmark[i]);
      end
      elig = e;
   endfunction : elig

   function automatic logic [3:0] arb(input logic [CMC_MB_MAX-1:0] e,
                                      input logic [CMC_MB_MAX-1:0][3:0] p);
      logic [3:0] best;
      logic       f;
      logic [2:0] w;
      f = 1'b0;
      w = '0;
      best = '0;
      for (int i = 0; i < CMC_MB_MAX; i++)
      begin
         if (e[i] && (!f || p[i] > best))
         begin
            f = 1'b1;
            best = p[i];
            w = 3'(i);
         end
      end
      arb = {f, w};
   endfunction : arb

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [2:0]            mi;
      logic                  mbok;
      logic [4:0]            mo;
      logic [CMC_MB_MAX-1:0] abreq;
      logic [CMC_MB_MAX-1:0] txreq;
      logic                  found;
      logic [3:0]            pick;
      mi = q.addr[7:5];
      mo = q.addr[4:0];
      mbok = (q.addr[11:8] == CMC_MB_PAGE) && (32'(mi) < MB_NUM);
      abreq = '0;
      txreq = '0;
      found = 1'b0;
      pick = '0;
      n = q;
      n.resp = 1'b0;
      n.rx_hit = 1'b0;
      n.rx_store = 1'b0;
      n.rx_drop = 1'b0;
      n.timer = q.timer + 16'h0001;
      // Read data is built one cycle after the address phase, so it always
      // sees the effect of a write that was in its data phase just before.
      if (q.rd_pend)
      begin
         n.rd_pend = 1'b0;
         n.ready = 1'b1;
         n.rdata = '0;
         if (q.addr == CMC_CFG_OFF)
            n.rdata[0] = q.ttm;
         else if (q.addr == CMC_TIM_OFF)
            n.rdata[15:0] = q.timer;
         else if (mbok)
         begin
            unique case (mo)
               CMC_MMR_OFF:
               begin
                  n.rdata[CMC_MOT_LSB+:3] = q.object_type[mi];
                  n.rdata[CMC_PRI_LSB+:4] = q.prior[mi];
                  n.rdata[15:0] = q.tmark[mi];
               end
               CMC_MAM_OFF:  n.rdata[29:0] = q.mask[mi];
               CMC_MID_OFF:  n.rdata[29:0] = q.id[mi];
               CMC_MASKED_FAMILY_IDENTIFIER_OFF: n.rdata[28:0] = fam_pack(q.id[mi], q.mask[mi]);
               CMC_MSR_OFF:
               begin
                  n.rdata[CMC_RDY_BIT] = q.rdy[mi];
                  n.rdata[CMC_ABT_BIT] = q.abt[mi];
                  n.rdata[CMC_PEND_BIT] = q.pend[mi];
               end
               default: n.rdata = '0;
            endcase
         end
      end
      // Write data phase; hardware events below may set what a write clears.
      if (q.wr_pend)
      begin
         n.wr_pend = 1'b0;
         if (q.addr == CMC_ACR_OFF)
            abreq = hwdata[CMC_MB_MAX-1:0];
         else if (q.addr == CMC_TCR_OFF)
         begin
            txreq = hwdata[CMC_MB_MAX-1:0];
            if (hwdata[CMC_TRST_BIT])
               n.timer = '0;
         end
         else if (q.addr == CMC_CFG_OFF)
         begin
            n.ttm = hwdata[0];
            if (!hwdata[0])
               n.tmark = '0;
         end
         else if (mbok)
         begin
            unique case (mo)
               CMC_MMR_OFF:
               begin
                  n.object_type[mi] = hwdata[CMC_MOT_LSB+:3];
                  n.prior[mi] = hwdata[CMC_PRI_LSB+:4];
                  n.tmark[mi] = q.ttm ? hwdata[15:0] : 16'h0000;
                  n.pend[mi] = 1'b0;
                  n.inflight[mi] = 1'b0;
                  n.rsent[mi] = 1'b0;
                  n.rgot[mi] = 1'b0;
                  n.abt[mi] = 1'b0;
                  n.rdy[mi] = (hwdata[CMC_MOT_LSB+:3] == CMC_OT_TX) ||
                              (hwdata[CMC_MOT_LSB+:3] == CMC_OT_PROD);
               end
               CMC_MAM_OFF: n.mask[mi] = hwdata[29:0];
               CMC_MID_OFF:
               begin
                  n.id[mi] = hwdata[29:0];
                  if (!hwdata[CMC_IDE_BIT])
                     n.id[mi][CMC_STD_LSB-1:0] = '0;
               end
               CMC_MCR_OFF:
               begin
                  n.rdy[mi] = 1'b0;
                  n.abt[mi] = 1'b0;
                  abreq[mi] = hwdata[CMC_ABREQ_BIT];
                  txreq[mi] = hwdata[CMC_TXREQ_BIT];
               end
               default: n.rdy = q.rdy;
            endcase
         end
      end
      // Transfer requests arm enabled mailboxes only.
      for (int i = 0; i < MB_NUM; i++)
      begin
         if (txreq[i] && q.object_type[i] != CMC_OT_OFF && q.object_type[i] <= CMC_OT_PROD)
         begin
            n.pend[i] = 1'b1;
            n.rdy[i] = 1'b0;
            n.abt[i] = 1'b0;
            n.rsent[i] = 1'b0;
            n.rgot[i] = 1'b0;
         end
      end
      // Transmit progress reported by the core.
      if (q.tx_valid && tx_start)
         n.inflight[q.tx_mb] = 1'b1;
      if (q.tx_valid && tx_done)
      begin
         n.inflight[q.tx_mb] = 1'b0;
         if (q.object_type[q.tx_mb] == CMC_OT_CONS)
            n.rsent[q.tx_mb] = 1'b1;
         else
         begin
            n.pend[q.tx_mb] = 1'b0;
            n.rgot[q.tx_mb] = 1'b0;
            n.rdy[q.tx_mb] = 1'b1;
         end
      end
      // Aborts; a frame already handed to the transceiver cannot be recalled.
      for (int i = 0; i < MB_NUM; i++)
      begin
         if (abreq[i] && n.pend[i] && !n.inflight[i] && is_txt(q.object_type[i]) &&
             !(q.object_type[i] == CMC_OT_CONS && n.rsent[i]))
         begin
            n.pend[i] = 1'b0;
            n.rgot[i] = 1'b0;
            n.abt[i] = 1'b1;
         end
      end
      // Receive acceptance: the lowest-numbered matching mailbox wins.
      if (rx_valid)
      begin
         for (int i = 0; i < MB_NUM; i++)
         begin
            if (!found && n.pend[i] && id_match(q.id[i], q.mask[i], rx_id) &&
                (((q.object_type[i] == CMC_OT_RX || q.object_type[i] == CMC_OT_RXOW) && !rx_rtr) ||
                 (q.object_type[i] == CMC_OT_CONS && n.rsent[i] && !rx_rtr) ||
                 (q.object_type[i] == CMC_OT_PROD && rx_rtr && !n.rgot[i])))
            begin
               found = 1'b1;
               n.rx_hit = 1'b1;
               n.rx_mb = 3'(i);
               if (q.object_type[i] == CMC_OT_RX && q.rdy[i])
                  n.rx_drop = 1'b1;
               else if (q.object_type[i] == CMC_OT_PROD)
                  n.rgot[i] = 1'b1;
               else
               begin
                  n.rx_store = 1'b1;
                  n.rdy[i] = 1'b1;
                  if (q.object_type[i] == CMC_OT_CONS)
                     n.pend[i] = 1'b0;
               end
            end
         end
      end
      // Offer the next transmit candidate from the updated state.
      pick = arb(elig(n), n.prior);
      n.tx_valid = pick[3];
      n.tx_mb = pick[2:0];
      n.tx_rtr = (n.object_type[pick[2:0]] == CMC_OT_CONS);
      n.irq = |n.abt;
      // Address phase; reads take one wait state.
      if (hsel && htrans[1] && hready)
      begin
         n.addr = {haddr[11:2], 2'b00};
         n.wr_pend = hwrite;
         n.rd_pend = !hwrite;
         n.ready = hwrite;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
         q.ready <= 1'b1;
      end
      else
         q <= n;
   end

   assign hreadyout = q.ready;
   assign hresp = q.resp;
   assign hrdata = q.rdata;
   assign tx_valid = q.tx_valid;
   assign tx_mb = q.tx_mb;
   assign tx_rtr = q.tx_rtr;
   assign rx_hit = q.rx_hit;
   assign rx_mb = q.rx_mb;
   assign rx_store = q.rx_store;
   assign rx_drop = q.rx_drop;
   assign abort_irq = q.irq;
   assign elig_q = elig(q);

   ////////////////////////////////////////////////////////////////////////////
   group_abort_a : assert property (@(posedge hclk) disable iff (!hresetn)
      q.wr_pend && q.addr == CMC_ACR_OFF && hwdata[0] && q.object_type[0] == CMC_OT_TX &&
      q.pend[0] && !q.inflight[0] && !(q.tx_valid && tx_start && q.tx_mb == 3'h0)
      |=> q.abt[0] && !q.pend[0])
      else $error("group abort did not cancel mailbox 0");

   rx_abort_a : assert property (@(posedge hclk) disable iff (!hresetn)
      q.wr_pend && q.addr == CMC_ACR_OFF && hwdata[1] && q.object_type[1] == CMC_OT_RX
      |=> !q.abt[1] && $stable(q.pend[1]))
      else $error("abort acted on a receive mailbox");

   prod_abort_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(q.pend[7]) && $rose(q.abt[7]) && q.object_type[7] == CMC_OT_PROD
      |-> !q.rgot[7] ##1 (!(rx_hit && rx_mb == 3'h7))[*8])
      else $error("aborted producer answered a remote frame");

   time_gate_a : assert property (@(posedge hclk) disable iff (!hresetn)
      q.tx_valid && q.ttm |-> q.timer >= q.tmark[q.tx_mb])
      else $error("transmit offered before timemark");

   stamp_zero_a : assert property (@(posedge hclk) disable iff (!hresetn)
      !q.ttm |-> q.tmark == '0)
      else $error("timemark nonzero in timestamp mode");

   tie_break_a : assert property (@(posedge hclk) disable iff (!hresetn)
      q.tx_valid && q.tx_mb == 3'h1 |-> !(elig_q[0] && q.prior[0] >= q.prior[1]))
      else $error("transmit arbitration order wrong");

   tx_type_a : assert property (@(posedge hclk) disable iff (!hresetn)
      q.tx_valid |-> is_txt(q.object_type[q.tx_mb]))
      else $error("transmit offered by a non-transmit mailbox");

   rx_keep_a : assert property (@(posedge hclk) disable iff (!hresetn)
      rx_valid ##1 q.rx_drop |-> q.object_type[q.rx_mb] == CMC_OT_RX && $past(q.rdy[q.rx_mb]))
      else $error("frame dropped without a full receive mailbox");

   ext_zero_a : assert property (@(posedge hclk) disable iff (!hresetn)
      !q.id[0][CMC_IDE_BIT] |-> q.id[0][CMC_STD_LSB-1:0] == '0)
      else $error("extended identifier part not zero");

   abort_irq_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(|q.abt) |-> abort_irq throughout (|q.abt)[*1])
      else $error("abort flag without interrupt");

endmodule : cmc_mailbox
`default_nettype wire

// file: cmc_pkg.sv
package cmc_pkg;
   localparam int CMC_MB_MAX = 8;
   // Byte offsets inside the 4 KB register window.
   localparam logic [11:0] CMC_ACR_OFF  = 12'h000;
   localparam logic [11:0] CMC_CFG_OFF  = 12'h004;
   localparam logic [11:0] CMC_TIM_OFF  = 12'h008;
   localparam logic [11:0] CMC_TCR_OFF  = 12'h00c;
   localparam logic [3:0]  CMC_MB_PAGE  = 4'h2;
   localparam logic [4:0]  CMC_MMR_OFF  = 5'h00;
   localparam logic [4:0]  CMC_MAM_OFF  = 5'h04;
   localparam logic [4:0]  CMC_MID_OFF  = 5'h08;
   localparam logic [4:0]  CMC_MASKED_FAMILY_IDENTIFIER_OFF = 5'h0c;
   localparam logic [4:0]  CMC_MSR_OFF  = 5'h10;
   localparam logic [4:0]  CMC_MCR_OFF  = 5'h1c;
   // Field positions.
   localparam int CMC_MOT_LSB   = 24;
   localparam int CMC_PRI_LSB   = 16;
   localparam int CMC_IDE_BIT   = 29;
   localparam int CMC_STD_LSB   = 18;
   localparam int CMC_TXREQ_BIT = 23;
   localparam int CMC_ABREQ_BIT = 22;
   localparam int CMC_RDY_BIT   = 23;
   localparam int CMC_ABT_BIT   = 22;
   localparam int CMC_PEND_BIT  = 21;
   localparam int CMC_TRST_BIT  = 31;
   // Object type codes.
   localparam logic [2:0] CMC_OT_OFF  = 3'h0;
   localparam logic [2:0] CMC_OT_RX   = 3'h1;
   localparam logic [2:0] CMC_OT_RXOW = 3'h2;
   localparam logic [2:0] CMC_OT_TX   = 3'h3;
   localparam logic [2:0] CMC_OT_CONS = 3'h4;
   localparam logic [2:0] CMC_OT_PROD = 3'h5;

   typedef struct packed {
      logic [CMC_MB_MAX-1:0][2:0]  object_type;
      logic [CMC_MB_MAX-1:0][3:0]  prior;
      logic [CMC_MB_MAX-1:0][15:0] tmark;
      logic [CMC_MB_MAX-1:0][29:0] mask;
      logic [CMC_MB_MAX-1:0][29:0] id;
      logic [CMC_MB_MAX-1:0]       pend;
      logic [CMC_MB_MAX-1:0]       inflight;
      logic [CMC_MB_MAX-1:0]       rsent;
      logic [CMC_MB_MAX-1:0]       rgot;
      logic [CMC_MB_MAX-1:0]       rdy;
      logic [CMC_MB_MAX-1:0]       abt;
      logic                        ttm;
      logic [15:0]                 timer;
      logic                        wr_pend;
      logic                        rd_pend;
      logic [11:0]                 addr;
      logic [31:0]                 rdata;
      logic                        ready;
      logic                        resp;
      logic                        tx_valid;
      logic [2:0]                  tx_mb;
      logic                        tx_rtr;
      logic                        rx_hit;
      logic [2:0]                  rx_mb;
      logic                        rx_store;
      logic                        rx_drop;
      logic                        irq;
   } cmc_state_s;
endpackage : cmc_pkg

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import cmc_pkg::*;
   typedef struct packed
   {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } cmc_row_s;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, go;
   logic        tx_valid, tx_rtr, tx_start, tx_done, rx_valid, rx_rtr, rx_hit, rx_store, rx_drop, abort_irq;
   logic [1:0]  htrans;
   logic [2:0]  hsize, tx_mb, rx_mb;
   logic [4:0]  gap;
   logic [28:0] rx_id;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [3:0]  txq[$];
   cmc_row_s    rows[5];
   int          bad_count, checked, cycles;

   cmc_mailbox #(.MB_NUM(8)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .tx_valid(tx_valid), .tx_mb(tx_mb), .tx_rtr(tx_rtr), .tx_start(tx_start),
      .tx_done(tx_done), .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_hit(rx_hit),
      .rx_mb(rx_mb), .rx_store(rx_store), .rx_drop(rx_drop), .abort_irq(abort_irq));
   cmc_core_model u_core (
      .hclk(hclk), .hresetn(hresetn), .tx_valid(tx_valid), .go(go), .gap(gap),
      .tx_start(tx_start), .tx_done(tx_done));

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cycles++;
      if (tx_start === 1'b1 && tx_valid === 1'b1)
         txq.push_back({tx_rtr, tx_mb});
      if (cycles == 20000)
      begin
         bad_count++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (bad_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk_w
   task automatic chk_b(input string n, input logic e, input logic g);
      chk_w(n, {31'h0, e}, {31'h0, g});
   endtask : chk_b
   function automatic logic [31:0] mba(input int mb, input logic [4:0] off);
      return 32'h200 + 32'(mb) * 32'h20 + {27'h0, off};
   endfunction : mba
   // Read data is taken only where ready is seen high, so the wait state count never matters.
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic wr(input logic [31:0] a, input logic [31:0] wd);
      logic [31:0] x;
      xfer(1'b1, a, wd, x);
   endtask : wr
   task automatic cfg(input int mb, input logic [31:0] mode, input logic [31:0] id, input logic [31:0] m);
      wr(mba(mb, CMC_MMR_OFF), 32'h0);
      wr(mba(mb, CMC_MID_OFF), id);
      wr(mba(mb, CMC_MAM_OFF), m);
      wr(mba(mb, CMC_MMR_OFF), mode);
   endtask : cfg
   task automatic aborted(input int mb, input logic e);
      xfer(1'b0, mba(mb, CMC_MSR_OFF), 32'h0, d);
      chk_b("aborted_flag", e, d[CMC_ABT_BIT]);
      chk_b("hresp", 1'b0, hresp);
   endtask : aborted
   task automatic wait_tx(input logic v);
      for (int i = 0; i < 300 && tx_valid !== v; i++)
         @(posedge hclk);
      #1;
   endtask : wait_tx
   task automatic expect_rx(input logic [28:0] id, input logic rtr, input logic eh, input logic [2:0] em,
                            input logic es, input logic ed);
      @(posedge hclk);
      rx_valid <= 1'b1;
      rx_id    <= id;
      rx_rtr   <= rtr;
      @(posedge hclk);
      rx_valid <= 1'b0;
      rx_id    <= ~id;
      rx_rtr   <= ~rtr;
      // The result pulses for one cycle after the edge that takes the frame.
      #1;
      chk_b("rx_hit", eh, rx_hit);
      if (eh)
         chk_w("rx_mb", {29'h0, em}, {29'h0, rx_mb});
      chk_b("rx_store", es, rx_store);
      chk_b("rx_drop", ed, rx_drop);
   endtask : expect_rx
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, rx_valid, rx_id, rx_rtr, go} = '0;
      hsize = 3'h2;
      gap = 5'h1;
      rows = '{'{32'h200, 32'h0305_1234, 32'h0305_0000}, '{32'h228, 32'h0005_5555, 32'h0004_0000},
               '{32'h228, 32'h2005_5555, 32'h2005_5555}, '{32'h224, 32'h3fff_ffff, 32'h3fff_ffff},
               '{32'h300, 32'h1234_5678, 32'h0}};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      chk_b("irq_reset", 1'b0, abort_irq);
      xfer(1'b0, mba(0, CMC_MMR_OFF), 32'h0, d);
      chk_w("mode_reset", 32'h0, d);
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdata);
         xfer(1'b0, rows[i].addr, 32'h0, d);
         chk_w("readback", rows[i].exp, d);
      end
      wr(mba(1, CMC_MMR_OFF), 32'h0);
      wr(mba(2, CMC_MID_OFF), 32'h305a_4321);
      wr(mba(2, CMC_MAM_OFF), 32'h3ff0_f0ff);
      xfer(1'b0, mba(2, CMC_MASKED_FAMILY_IDENTIFIER_OFF), 32'h0, d);
      chk_w("family_id", 32'h0010_5421, d);
      // Transmit arbitration with the core stalled, then released.
      wr(mba(3, CMC_MMR_OFF), 32'h0302_0000);
      wr(mba(5, CMC_MMR_OFF), 32'h0305_0000);
      wr(mba(6, CMC_MMR_OFF), 32'h0305_0000);
      wr(32'(CMC_TCR_OFF), 32'h68);
      wait_tx(1'b1);
      chk_w("first_offer", 32'h5, {29'h0, tx_mb});
      go <= 1'b1;
      for (int i = 0; i < 300 && txq.size() < 3; i++)
         @(posedge hclk);
      chk_w("tx_order", 32'h0000_0563, {20'h0, txq[0], txq[1], txq[2]});
      xfer(1'b0, mba(3, CMC_MSR_OFF), 32'h0, d);
      chk_b("tx_ready", 1'b1, d[CMC_RDY_BIT]);
      go <= 1'b0;
      wr(mba(0, CMC_MMR_OFF), 32'h0300_0000);
      wr(mba(1, CMC_MMR_OFF), 32'h0100_0000);
      wr(32'(CMC_TCR_OFF), 32'h3);
      wr(32'(CMC_ACR_OFF), 32'h3);
      aborted(0, 1'b1);
      aborted(1, 1'b0);
      chk_b("irq_set", 1'b1, abort_irq);
      wr(mba(0, CMC_MCR_OFF), 32'h0);
      wr(mba(0, CMC_MCR_OFF), 32'h0080_0000);
      chk_b("irq_clear", 1'b0, abort_irq);
      wr(mba(0, CMC_MCR_OFF), 32'h0040_0000);
      aborted(0, 1'b1);
      wr(mba(0, CMC_MCR_OFF), 32'h0080_0000);
      gap <= 5'd20;
      go <= 1'b1;
      for (int i = 0; i < 300 && tx_start !== 1'b1; i++)
         @(posedge hclk);
      wr(32'(CMC_ACR_OFF), 32'h1);
      aborted(0, 1'b0);
      wait_tx(1'b0);
      go <= 1'b0;
      gap <= 5'h1;
      // Time-triggered mode: mark at 64 timer counts after the timer reset.
      wr(32'(CMC_CFG_OFF), 32'h1);
      wr(mba(3, CMC_MMR_OFF), 32'h0300_0040);
      wr(32'(CMC_TCR_OFF), 32'h8000_0008);
      repeat (40) @(posedge hclk);
      chk_b("before_mark", 1'b0, tx_valid);
      repeat (40) @(posedge hclk);
      chk_b("after_mark", 1'b1, tx_valid);
      wr(32'(CMC_CFG_OFF), 32'h0);
      xfer(1'b0, mba(3, CMC_MMR_OFF), 32'h0, d);
      chk_w("mark_zeroed", 32'h0300_0000, d);
      go <= 1'b1;
      wait_tx(1'b0);
      wr(mba(1, CMC_MMR_OFF), 32'h0);
      cfg(4, 32'h0100_0000, {3'b001, 11'h123, 18'h55}, 32'h3fff_ffff);
      wr(32'(CMC_TCR_OFF), 32'h10);
      expect_rx({11'h123, 18'h56}, 1'b0, 1'b0, 3'd4, 1'b0, 1'b0);
      expect_rx({11'h123, 18'h55}, 1'b0, 1'b1, 3'd4, 1'b1, 1'b0);
      cfg(4, 32'h0100_0000, {3'b001, 11'h123, 18'h55}, 32'h1fff_ffff);
      wr(32'(CMC_TCR_OFF), 32'h10);
      expect_rx({11'h123, 18'h56}, 1'b0, 1'b1, 3'd4, 1'b1, 1'b0);
      wr(mba(4, CMC_MMR_OFF), 32'h0);
      cfg(1, 32'h0100_0000, {3'b000, 11'h2a5, 18'h0}, 32'h1ffc_0000);
      cfg(2, 32'h0200_0000, {3'b000, 11'h2a5, 18'h0}, 32'h1ffc_0000);
      cfg(0, 32'h0600_0000, {3'b000, 11'h2a5, 18'h0}, 32'h1ffc_0000);
      wr(32'(CMC_TCR_OFF), 32'h7);
      expect_rx({11'h2a5, 18'h0}, 1'b0, 1'b1, 3'd1, 1'b1, 1'b0);
      expect_rx({11'h2a5, 18'h0}, 1'b0, 1'b1, 3'd1, 1'b0, 1'b1);
      wr(mba(1, CMC_MMR_OFF), 32'h0);
      expect_rx({11'h2a5, 18'h0}, 1'b0, 1'b1, 3'd2, 1'b1, 1'b0);
      expect_rx({11'h2a5, 18'h0}, 1'b0, 1'b1, 3'd2, 1'b1, 1'b0);
      go <= 1'b0;
      cfg(6, 32'h0400_0000, {3'b000, 11'h3c1, 18'h0}, 32'h1ffc_0000);
      wr(32'(CMC_TCR_OFF), 32'h40);
      wait_tx(1'b1);
      chk_w("consumer_offer", 32'he, {28'h0, tx_rtr, tx_mb});
      wr(32'(CMC_ACR_OFF), 32'h40);
      aborted(6, 1'b1);
      wr(32'(CMC_TCR_OFF), 32'h40);
      go <= 1'b1;
      for (int i = 0; i < 300 && tx_done !== 1'b1; i++)
         @(posedge hclk);
      expect_rx({11'h3c1, 18'h0}, 1'b0, 1'b1, 3'd6, 1'b1, 1'b0);
      go <= 1'b0;
      cfg(7, 32'h0500_0000, {3'b000, 11'h0f0, 18'h0}, 32'h1ffc_0000);
      wr(32'(CMC_TCR_OFF), 32'h80);
      repeat (5) @(posedge hclk);
      chk_b("producer_idle", 1'b0, tx_valid);
      expect_rx({11'h0f0, 18'h0}, 1'b1, 1'b1, 3'd7, 1'b0, 1'b0);
      wait_tx(1'b1);
      chk_w("producer_offer", 32'h7, {28'h0, tx_rtr, tx_mb});
      wr(32'(CMC_ACR_OFF), 32'h80);
      aborted(7, 1'b1);
      expect_rx({11'h0f0, 18'h0}, 1'b1, 1'b0, 3'd7, 1'b0, 1'b0);
      chk_b("producer_silent", 1'b0, tx_valid);
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
